// *** dcbt_regs.vh ***
// Register map, field positions, reset values and bus codes of the DMA channel.
// Included by the channel top, its checker and its bench; holds definitions only.
`ifndef DCBT_REGS_VH
`define DCBT_REGS_VH

// ***********************************************
// Register offsets (low 24 address bits)
// ***********************************************
`define DCBT_SRC_OFS      24'hff_fc00
`define DCBT_DST_OFS      24'hff_fc04
`define DCBT_CNT_OFS      24'hff_fc0c
`define DCBT_BSZ_OFS      24'hff_fc10
`define DCBT_CTL_OFS      24'hff_fc14
`define DCBT_STS_OFS      24'hff_fc18
`define DCBT_MSK_OFS      24'hff_fc1c

// ***********************************************
// Control register fields
// ***********************************************
`define DCBT_TE_BIT       31
`define DCBT_NRD_BIT      26
`define DCBT_TIF_BIT      16
`define DCBT_SIZE_HI      15
`define DCBT_SIZE_LO      14
`define DCBT_MODE_HI      13
`define DCBT_MODE_LO      12
`define DCBT_SIZE_BYTE    2'h0
`define DCBT_SIZE_WORD    2'h1
`define DCBT_SIZE_LONG    2'h2
`define DCBT_MODE_NORMAL  2'h0
`define DCBT_MODE_BLOCK   2'h1

// ***********************************************
// Status and mask fields
// ***********************************************
`define DCBT_STS_END_BIT  0
`define DCBT_STS_BLK_BIT  1

// ***********************************************
// Reset values and sizes
// ***********************************************
`define DCBT_REG_RST      32'h0000_0000
`define DCBT_BUF_WORDS    5'h10
`define DCBT_BLEN_HI      31
`define DCBT_BLEN_LO      16

// ***********************************************
// AHB-Lite codes
// ***********************************************
`define DCBT_HTRANS_IDLE  2'h0
`define DCBT_HTRANS_NSEQ  2'h2

`endif

// *** dcbt_buf.v ***
// Block buffer of the DMA channel: 16 longwords, one write and one read port.
// Assumes one clock; read data appear one edge after the read address.
`timescale 1ns/1ps
`default_nettype none

module dcbt_buf (
   input  wire        clk,
   input  wire        we,
   input  wire [3:0]  waddr,
   input  wire [31:0] wdata,
   input  wire [3:0]  raddr,
   output reg  [31:0] rdata
);

   reg [31:0] mem [0:15];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // dcbt_buf

`default_nettype wire

// *** dcbt_top.v ***
// One DMA channel: AHB-Lite register slave plus an AHB-Lite master that copies
// data from source to destination, single transfers, in normal or block mode.
// Assumes hclk at 40 MHz, xfer_req driven by logic on hclk, one slave on the
// master port whose hreadyout is m_hready.
//
// Contract
// - Read start address comes from a 32-bit writable source address register.
// - Write start address comes from a 32-bit writable destination address register.
// - Total bytes to move come from a 32-bit transfer count register.
// - Block size register sets block length, used only in block mode.
// - Block size 0x00040004 means four longwords, sixteen bytes per block.
// - Transfers run only while control bit 31 is one; the code tests it only in S_IDLE, so a block under way completes.
// - Delay bit 26 clear: next request accepted right after completion.
// - Delay bit 26 set: next request accepted one cycle after completion.
// - Interrupt flag at control bit 16, readable, write may only clear it.
// - Flag set when the counter requests transfer end, else reads zero.
// - Bits 15:14 select access width; code 10 means longword accesses.
// - Bits 13:12 select mode; code 01 means block transfer mode.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcbt_regs.vh"

module dcbt_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   output reg  [31:0] m_haddr,
   output reg  [1:0]  m_htrans,
   output reg         m_hwrite,
   output reg  [2:0]  m_hsize,
   output reg  [31:0] m_hwdata,
   input  wire [31:0] m_hrdata,
   input  wire        m_hready,
   input  wire        xfer_req,
   output reg         irq
);

   // ***********************************************
   // States
   // ***********************************************
   localparam [6:0] S_IDLE = 7'b000_0001;
   localparam [6:0] S_RA   = 7'b000_0010;
   localparam [6:0] S_RD   = 7'b000_0100;
   localparam [6:0] S_WP   = 7'b000_1000;
   localparam [6:0] S_WA   = 7'b001_0000;
   localparam [6:0] S_WD   = 7'b010_0000;
   localparam [6:0] S_GAP  = 7'b100_0000;

   localparam [2:0] R_SRC  = 3'd0;
   localparam [2:0] R_DST  = 3'd1;
   localparam [2:0] R_CNT  = 3'd2;
   localparam [2:0] R_BSZ  = 3'd3;
   localparam [2:0] R_CTL  = 3'd4;
   localparam [2:0] R_STS  = 3'd5;
   localparam [2:0] R_MSK  = 3'd6;
   localparam [2:0] R_NONE = 3'd7;

   // ***********************************************
   // Functions
   // ***********************************************
   function [2:0] dcbt_dec;
      input [31:0] a;
      begin
         case (a[23:0])
            `DCBT_SRC_OFS: dcbt_dec = R_SRC;
            `DCBT_DST_OFS: dcbt_dec = R_DST;
            `DCBT_CNT_OFS: dcbt_dec = R_CNT;
            `DCBT_BSZ_OFS: dcbt_dec = R_BSZ;
            `DCBT_CTL_OFS: dcbt_dec = R_CTL;
            `DCBT_STS_OFS: dcbt_dec = R_STS;
            `DCBT_MSK_OFS: dcbt_dec = R_MSK;
            default:       dcbt_dec = R_NONE;
         endcase
      end
   endfunction

   function [31:0] dcbt_step;
      input [1:0] sz;
      begin
         case (sz)
            `DCBT_SIZE_BYTE: dcbt_step = 32'h0000_0001;
            `DCBT_SIZE_WORD: dcbt_step = 32'h0000_0002;
            default:         dcbt_step = 32'h0000_0004;
         endcase
      end
   endfunction

   // ***********************************************
   // Registers
   // ***********************************************
   reg  [31:0] src_q;
   reg  [31:0] dst_q;
   reg  [31:0] cnt_q;
   reg  [31:0] bsz_q;
   reg         te_q;
   reg         nrd_q;
   reg         tif_q;
   reg  [1:0]  size_q;
   reg  [1:0]  mode_q;
   reg  [1:0]  sts_q;
   reg  [1:0]  msk_q;
   reg  [6:0]  st_q;
   reg  [4:0]  idx_q;
   reg  [4:0]  nw_q;
   reg  [31:0] rleft_q;
   reg         wr_pend_q;
   reg  [2:0]  wsel_q;

   reg  [1:0]  sts_d;
   reg  [31:0] rd_val;
   reg  [4:0]  blen;

   wire [31:0] step     = dcbt_step(size_q);
   wire        busy     = (st_q != S_IDLE) && (st_q != S_GAP);
   wire        acc      = hsel & htrans[1] & hready;
   wire [2:0]  asel     = dcbt_dec(haddr);
   wire        rd_sts   = acc & ~hwrite & (asel == R_STS);
   wire        m_ack    = m_hready;
   wire        end_ev   = (st_q == S_WD) && m_ack && (cnt_q <= step);
   wire        blk_ev   = (st_q == S_WD) && m_ack && !end_ev && ((idx_q + 5'd1) == nw_q);
   wire        rd_last  = ((idx_q + 5'd1) == nw_q) || (rleft_q <= step);
   wire [31:0] ctl_val  = {te_q, 4'h0, nrd_q, 9'h000, tif_q, size_q, mode_q, 12'h000};
   wire        buf_we   = (st_q == S_RD) && m_ack;
   wire [4:0]  ridx     = (st_q == S_WD) ? (idx_q + 5'd1) : idx_q;
   wire [31:0] buf_rd;
   wire [15:0] bs_words = bsz_q[`DCBT_BLEN_HI:`DCBT_BLEN_LO];

   // ***********************************************
   // Block buffer
   // ***********************************************
   dcbt_buf u_buf (
      .clk   (hclk),
      .we    (buf_we),
      .waddr (idx_q[3:0]),
      .wdata (m_hrdata),
      .raddr (ridx[3:0]),
      .rdata (buf_rd)
   );

   // ***********************************************
   // Read mux and block length
   // ***********************************************
   always @* begin
      case (asel)
         R_SRC:   rd_val = src_q;
         R_DST:   rd_val = dst_q;
         R_CNT:   rd_val = cnt_q;
         R_BSZ:   rd_val = bsz_q;
         R_CTL:   rd_val = ctl_val;
         R_STS:   rd_val = {30'h0000_0000, sts_q};
         R_MSK:   rd_val = {30'h0000_0000, msk_q};
         default: rd_val = `DCBT_REG_RST;
      endcase
   end

   // Words per block, clipped to the buffer
   always @* begin
      if (mode_q != `DCBT_MODE_BLOCK) begin
         blen = 5'd1;
      end else if (bs_words == 16'h0000) begin
         blen = 5'd1;
      end else if (bs_words > {11'h000, `DCBT_BUF_WORDS}) begin
         blen = `DCBT_BUF_WORDS;
      end else begin
         blen = bs_words[4:0];
      end
   end

   // Sticky status: set wins over read-clear
   always @* begin
      sts_d = rd_sts ? 2'b00 : sts_q;
      if (end_ev) begin
         sts_d[`DCBT_STS_END_BIT] = 1'b1;
      end
      if (blk_ev) begin
         sts_d[`DCBT_STS_BLK_BIT] = 1'b1;
      end
   end

   // ***********************************************
   // Slave side
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= `DCBT_REG_RST;
         wr_pend_q <= 1'b0;
         wsel_q    <= R_NONE;
         sts_q     <= 2'b00;
         irq       <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= acc & hwrite;
         if (acc) begin
            wsel_q <= asel;
         end
         if (acc & ~hwrite) begin
            hrdata <= rd_val;
         end
         sts_q <= sts_d;
         irq   <= |(sts_d & ((wr_pend_q && wsel_q == R_MSK) ? hwdata[1:0] : msk_q));
      end
   end

   // ***********************************************
   // Registers and transfer engine
   // ***********************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_q    <= `DCBT_REG_RST;
         dst_q    <= `DCBT_REG_RST;
         cnt_q    <= `DCBT_REG_RST;
         bsz_q    <= `DCBT_REG_RST;
         te_q     <= 1'b0;
         nrd_q    <= 1'b0;
         tif_q    <= 1'b0;
         size_q   <= `DCBT_SIZE_BYTE;
         mode_q   <= `DCBT_MODE_NORMAL;
         msk_q    <= 2'b00;
         st_q     <= S_IDLE;
         idx_q    <= 5'd0;
         nw_q     <= 5'd1;
         rleft_q  <= `DCBT_REG_RST;
         m_haddr  <= `DCBT_REG_RST;
         m_htrans <= `DCBT_HTRANS_IDLE;
         m_hwrite <= 1'b0;
         m_hsize  <= 3'b000;
         m_hwdata <= `DCBT_REG_RST;
      end else begin
         // Software writes, data phase
         if (wr_pend_q) begin
            case (wsel_q)
               R_SRC: if (!busy) src_q <= hwdata;
               R_DST: if (!busy) dst_q <= hwdata;
               R_CNT: if (!busy) cnt_q <= hwdata;
               R_BSZ: if (!busy) bsz_q <= hwdata;
               R_CTL: begin
                  te_q   <= hwdata[`DCBT_TE_BIT];
                  nrd_q  <= hwdata[`DCBT_NRD_BIT];
                  size_q <= hwdata[`DCBT_SIZE_HI:`DCBT_SIZE_LO];
                  mode_q <= hwdata[`DCBT_MODE_HI:`DCBT_MODE_LO];
                  if (!hwdata[`DCBT_TIF_BIT]) begin
                     tif_q <= 1'b0;
                  end
               end
               R_MSK: msk_q <= hwdata[1:0];
               default: ;
            endcase
         end
         // Engine
         case (st_q)
            S_IDLE: begin
               if (te_q && (cnt_q != 32'h0000_0000) && xfer_req) begin
                  nw_q     <= blen;
                  idx_q    <= 5'd0;
                  rleft_q  <= cnt_q;
                  m_haddr  <= src_q;
                  m_hwrite <= 1'b0;
                  m_hsize  <= {1'b0, (size_q == 2'b11) ? `DCBT_SIZE_LONG : size_q};
                  m_htrans <= `DCBT_HTRANS_NSEQ;
                  st_q     <= S_RA;
               end
            end
            S_RA: begin
               if (m_ack) begin
                  m_htrans <= `DCBT_HTRANS_IDLE;
                  st_q     <= S_RD;
               end
            end
            S_RD: begin
               if (m_ack) begin
                  src_q   <= src_q + step;
                  rleft_q <= (rleft_q > step) ? (rleft_q - step) : 32'h0000_0000;
                  if (rd_last) begin
                     nw_q  <= idx_q + 5'd1;
                     idx_q <= 5'd0;
                     st_q  <= S_WP;
                  end else begin
                     idx_q    <= idx_q + 5'd1;
                     m_haddr  <= src_q + step;
                     m_htrans <= `DCBT_HTRANS_NSEQ;
                     st_q     <= S_RA;
                  end
               end
            end
            S_WP: begin
               // Buffer read latency before the first write
               m_haddr  <= dst_q;
               m_hwrite <= 1'b1;
               m_htrans <= `DCBT_HTRANS_NSEQ;
               st_q     <= S_WA;
            end
            S_WA: begin
               if (m_ack) begin
                  m_htrans <= `DCBT_HTRANS_IDLE;
                  m_hwdata <= buf_rd;
                  st_q     <= S_WD;
               end
            end
            S_WD: begin
               if (m_ack) begin
                  dst_q <= dst_q + step;
                  cnt_q <= (cnt_q > step) ? (cnt_q - step) : 32'h0000_0000;
                  if (end_ev) begin
                     te_q     <= 1'b0;
                     tif_q    <= 1'b1;
                     m_hwrite <= 1'b0;
                     st_q     <= nrd_q ? S_GAP : S_IDLE;
                  end else if (blk_ev) begin
                     m_hwrite <= 1'b0;
                     st_q     <= nrd_q ? S_GAP : S_IDLE;
                  end else begin
                     idx_q    <= idx_q + 5'd1;
                     m_haddr  <= dst_q + step;
                     m_htrans <= `DCBT_HTRANS_NSEQ;
                     st_q     <= S_WA;
                  end
               end
            end
            S_GAP: begin
               st_q <= S_IDLE;
            end
            default: begin
               st_q     <= S_IDLE;
               m_htrans <= `DCBT_HTRANS_IDLE;
            end
         endcase
      end
   end

endmodule // dcbt_top

`default_nettype wire

// *** dcbt_mem_model.sv ***
// Memory slave on the channel's master port, 64 longwords, optional wait states.
// Assumes word-aligned single transfers driven on hclk.
`timescale 1ns/1ps
`default_nettype none
module dcbt_mem_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        slow,
   output logic             hready,
   output logic [31:0]      hrdata
);
   logic [31:0] mem [0:63];
   logic [31:0] last_q;
   logic [5:0]  idx_q;
   logic [1:0]  wait_q;
   logic        dp_q;
   logic        wr_q;
   initial for (int i = 0; i < 64; i++) mem[i] = 32'h5a5a_0000 + i;
   // Released data line toggles so no stale word can pass
   assign hrdata = (dp_q && !wr_q) ? mem[idx_q] : ~last_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q   <= 1'b0;
         wr_q   <= 1'b0;
         hready <= 1'b1;
         last_q <= 32'h0000_0000;
      end else begin
         last_q <= hrdata;
         if (dp_q && hready && wr_q) mem[idx_q] <= hwdata;
         if (htrans[1] && hready) begin
            dp_q   <= 1'b1;
            wr_q   <= hwrite;
            idx_q  <= haddr[7:2];
            wait_q <= slow ? 2'h2 : 2'h0;
            hready <= !slow;
         end else if (dp_q && hready) begin
            dp_q <= 1'b0;
         end else if (dp_q) begin
            wait_q <= wait_q - 2'h1;
            hready <= (wait_q == 2'h1);
         end
      end
   end
endmodule // dcbt_mem_model
`default_nettype wire

// *** dcbt_top_props.sv ***
// Checker of the DMA channel top, bound to its ports.
// Assumes one hclk domain and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "dcbt_regs.vh"
module dcbt_top_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [31:0] m_haddr,
   input wire logic [1:0]  m_htrans,
   input wire logic        m_hwrite,
   input wire logic [2:0]  m_hsize,
   input wire logic [31:0] m_hwdata,
   input wire logic [31:0] m_hrdata,
   input wire logic        m_hready,
   input wire logic        xfer_req,
   input wire logic        irq
);
   logic wdp_q;
   logic lastw_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ***********************
   // Master phase tracking
   // ***********************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdp_q   <= 1'b0;
         lastw_q <= 1'b0;
      end else if (m_hready) begin
         wdp_q <= m_htrans[1] & m_hwrite;
         if (m_htrans[1]) lastw_q <= m_hwrite;
      end
   end
   ready_okay_a: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
   reset_idle_a: assert property ($rose(hresetn) |-> m_htrans == 2'h0 && !irq && hrdata == 32'h0000_0000)
      else $error("not idle after reset");
   addr_hold_a: assert property (m_htrans[1] && !m_hready |=> m_htrans[1] && $stable(m_haddr))
      else $error("address phase dropped");
   single_xfer_a: assert property (m_htrans[1] && m_hready |=> m_htrans == 2'h0) else $error("burst seen");
   wdata_hold_a: assert property (wdp_q && !m_hready |=> $stable(m_hwdata)) else $error("write data moved");
   rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data moved");
   write_gap_a: assert property (m_htrans[1] && m_hwrite && !lastw_q |->
      $past(m_htrans, 1) == 2'h0 && $past(m_htrans, 2) == 2'h0) else $error("write overlaps read");
   irq_clear_a: assert property (hsel && htrans[1] && hready && !hwrite
      && haddr[23:0] == `DCBT_STS_OFS && !wdp_q |-> ##[1:2] !irq) else $error("irq kept after status read");
   size_legal_a: assert property (m_htrans[1] |-> !m_hsize[2] && m_hsize[1:0] != 2'b11)
      else $error("illegal master size");
   irq_seen_c: cover property ($rose(irq));
   first_wr_c: cover property (m_htrans[1] && m_hwrite && !lastw_q);
   stall_c: cover property (m_htrans[1] && !m_hready);
endmodule // dcbt_top_props
bind dcbt_top dcbt_top_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite),
   .m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
   .xfer_req(xfer_req), .irq(irq));
`default_nettype wire

// *** dcbt_top_bench.sv ***
// Self-checking bench of the DMA channel: AHB-Lite register tasks, memory model.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dcbt_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module dcbt_top_bench;
   logic        hclk, hresetn, hsel, hwrite, xfer_req, slow;
   logic [31:0] haddr, hwdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire  [31:0] hrdata, m_haddr, m_hwdata, m_hrdata;
   wire  [1:0]  m_htrans;
   wire  [2:0]  m_hsize;
   wire         hreadyout, hresp, m_hwrite, m_hready, irq;
   int          fails, samples_checked, cyc, nwr, bad_sz;
   logic [2:0]  exp_sz;
   int          rd_t[$];
   dcbt_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite),
      .m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
      .xfer_req(xfer_req), .irq(irq));
   dcbt_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .haddr(m_haddr), .htrans(m_htrans),
      .hwrite(m_hwrite), .hwdata(m_hwdata), .slow(slow), .hready(m_hready), .hrdata(m_hrdata));
   initial begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (m_htrans == 2'h2 && m_hready === 1'b1) begin
         if (m_hsize !== exp_sz) bad_sz++;
         if (m_hwrite) nwr++;
         else rd_t.push_back(cyc);
      end
   end
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wait_rdy;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin fails++; stop_test; end
   endtask
   // ***********************
   // Register bus access
   // ***********************
   task bus(input logic w, input logic [23:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {8'h00, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
   endtask
   task wr(input logic [23:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
   task rdc(input logic [23:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0); `CHK(r, e) endtask
   task run_xfer(input logic [31:0] ctl);
      int n;
      wr(`DCBT_CTL_OFS, ctl);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin @(posedge hclk); n++; end
      if (n >= 2000) begin fails++; stop_test; end
      xfer_req <= 1'b0;
   endtask
   task t_regs;
      rdc(`DCBT_CTL_OFS, 32'h0000_0000);
      wr(`DCBT_SRC_OFS, 32'h0000_0010);
      wr(`DCBT_DST_OFS, 32'h0000_0090);
      wr(`DCBT_CNT_OFS, 32'h0000_0010);
      wr(`DCBT_BSZ_OFS, 32'h0004_0004);
      wr(`DCBT_MSK_OFS, 32'h0000_0001);
      rdc(`DCBT_SRC_OFS, 32'h0000_0010);
      rdc(`DCBT_DST_OFS, 32'h0000_0090);
      rdc(`DCBT_CNT_OFS, 32'h0000_0010);
      rdc(`DCBT_BSZ_OFS, 32'h0004_0004);
      rdc(24'hff_fc20, 32'h0000_0000);
   endtask
   task t_block;
      xfer_req <= 1'b1;
      slow <= 1'b1;
      nwr = 0;
      repeat (20) @(posedge hclk);
      `CHK(nwr, 0)
      run_xfer(32'h8000_9000);
      `CHK(nwr, 4)
      for (int i = 0; i < 4; i++) `CHK(i_mem.mem[36 + i], 32'h5a5a_0004 + i)
      rdc(`DCBT_CNT_OFS, 32'h0000_0000);
      rdc(`DCBT_CTL_OFS, 32'h0001_9000);
      bus(1'b0, `DCBT_STS_OFS, 32'h0);
      `CHK(r[1:0], 2'b01)
      wr(`DCBT_CTL_OFS, 32'h0001_9000);
      rdc(`DCBT_CTL_OFS, 32'h0001_9000);
      wr(`DCBT_CTL_OFS, 32'h0000_0000);
      rdc(`DCBT_CTL_OFS, 32'h0000_0000);
   endtask
   task t_delay(input logic next_request_delay, input int gap);
      logic [31:0] s;
      s = next_request_delay ? 32'h0000_0040 : 32'h0000_0020;
      wr(`DCBT_SRC_OFS, s);
      wr(`DCBT_DST_OFS, s + 32'h0000_0080);
      wr(`DCBT_CNT_OFS, 32'h0000_0008);
      rd_t.delete();
      slow <= 1'b0;
      xfer_req <= 1'b1;
      run_xfer({1'b1, 4'h0, next_request_delay, 26'h000_8000});
      `CHK(rd_t.size(), 2)
      `CHK(rd_t[1] - rd_t[0], gap)
      `CHK(i_mem.mem[s[7:2] + 33], 32'h5a5a_0001 + s[7:2])
   endtask
   task t_mask;
      wr(`DCBT_MSK_OFS, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b0)
      wr(`DCBT_MSK_OFS, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b1)
      bus(1'b0, `DCBT_STS_OFS, 32'h0);
      `CHK(r[1:0], 2'b11)
      rdc(`DCBT_STS_OFS, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      `CHK(irq, 1'b0)
   endtask
   // Halfword accesses in normal mode, one unit per request
   task t_half;
      bus(1'b0, `DCBT_STS_OFS, 32'h0);
      `CHK(r[1:0], 2'b11)
      wr(`DCBT_SRC_OFS, 32'h0000_0060);
      wr(`DCBT_DST_OFS, 32'h0000_00e0);
      wr(`DCBT_CNT_OFS, 32'h0000_0004);
      rd_t.delete();
      exp_sz = 3'h1;
      xfer_req <= 1'b1;
      run_xfer(32'h8000_4000);
      exp_sz = 3'h2;
      `CHK(rd_t.size(), 2)
      `CHK(rd_t[1] - rd_t[0], 6)
      `CHK(i_mem.mem[56], 32'h5a5a_0018)
      `CHK(bad_sz, 0)
      rdc(`DCBT_SRC_OFS, 32'h0000_0064);
      rdc(`DCBT_DST_OFS, 32'h0000_00e4);
   endtask
   initial begin
      {hresetn, hsel, hwrite, xfer_req, slow, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      exp_sz = 3'h2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_block;
      t_delay(1'b0, 6);
      t_mask;
      t_delay(1'b1, 7);
      t_half;
      stop_test;
   end
   initial begin
      #2_000_000;
      fails++;
      stop_test;
   end
endmodule // dcbt_top_bench
`default_nettype wire
